/* rtl/lcpb_map.svh */
// Offsets, field positions, reset values and timing counts
`ifndef LCPB_MAP_SVH
`define LCPB_MAP_SVH
`define LCPB_CTRL_OFS      12'h000
`define LCPB_STAT_OFS      12'h004
`define LCPB_IRQ_STAT_OFS  12'h008
`define LCPB_IRQ_CLR_OFS   12'h00C
`define LCPB_IRQ_EN_OFS    12'h010
`define LCPB_CTRL_RST      32'h0000_0000
`define LCPB_IRQ_EN_RST    4'h0
// Control fields
`define LCPB_CTRL_STOPS_DONE 0
`define LCPB_CTRL_TUNE_DONE  1
// Interrupt event positions
`define LCPB_EV_START   0
`define LCPB_EV_DONE    1
`define LCPB_EV_CANCEL  2
`define LCPB_EV_REJECT  3
// Times
`define LCPB_CLK_HZ     100000000
`define LCPB_MIN_HOLD_MS 2000
`define LCPB_MAX_HOLD_MS 7000
`define LCPB_BLINK_MS    250
`define LCPB_MIN_HOLD_CYC ((`LCPB_CLK_HZ / 1000) * `LCPB_MIN_HOLD_MS)
`define LCPB_MAX_HOLD_CYC ((`LCPB_CLK_HZ / 1000) * `LCPB_MAX_HOLD_MS)
`define LCPB_BLINK_CYC    ((`LCPB_CLK_HZ / 1000) * `LCPB_BLINK_MS)
`endif

/* rtl/lcpb_pkg.sv */
// Types of the pushbutton commissioning controller
package lcpb_pkg;
  typedef enum logic [3:0] {
    LCPB_NORMAL = 4'b0001,
    LCPB_STOPS  = 4'b0010,
    LCPB_OPEN   = 4'b0100,
    LCPB_TUNE   = 4'b1000
  } lcpb_mode_t;
  typedef enum logic [1:0] {
    LCPB_BTN_NONE  = 2'h0,
    LCPB_BTN_STOPS = 2'h1,
    LCPB_BTN_UPPER = 2'h2,
    LCPB_BTN_TUNE  = 2'h3
  } lcpb_btn_t;
  typedef struct packed {
    lcpb_mode_t  mode;
    logic [31:0] hold_cnt;
    logic [31:0] blink_cnt;
    logic        blink;
    logic [1:0]  held;
    logic [2:0]  led;
    logic        air_closes_valve;
    logic        auto_tune_sel;
    logic [2:0]  preset_idx;
    logic        store_open_stop;
    logic        use_new_tune;
    logic [1:0]  done_ctl;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic        irq;
    logic        dphase;
    logic        dwrite;
    logic [11:0] daddr;
    logic [31:0] rdata;
  } lcpb_state_t;
endpackage : lcpb_pkg

/* rtl/lcpb_ctrl.sv */
// Pushbutton commissioning controller with AHB-Lite status port
// Contract
// - Selector 0-7 means air opens valve, 8-F means air closes valve.
// - Selector 0 or 8 selects auto-tuned parameters, not a preset.
// - Selectors 1-7 and 9-F select presets, smallest actuator first.
// - Stop-find LED lights at two seconds; release before seven starts.
// - LED 1 blinks continuously while stop finding runs.
// - Stop finding done returns to Normal by itself.
// - Upper button held two to seven seconds enters open-stop, LED 2.
// - Second upper hold over two seconds stores stop, LED off, Normal; the hold count runs on, so release before seven re-enters open-stop.
// - Autotune held two to seven seconds lights LED 2, then LED 3 blinks.
// - Tuning steps the valve; takes three to ten minutes.
// - Tuning done returns to Normal using the new parameters.
// - Cancel aborts any process, LED off, Normal, nothing changed.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "lcpb_map.svh"
`default_nettype none
module lcpb_ctrl
  import lcpb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // Front panel
  input  wire logic        stops_btn_in,
  input  wire logic        upper_btn_in,
  input  wire logic        tune_btn_in,
  input  wire logic        cancel_btn_in,
  input  wire logic [3:0]  selector_in,
  // Positioning engine, panel LEDs, interrupt
  input  wire logic        stops_done_in,
  input  wire logic        tune_done_in,
  output logic      [3:0]  mode_out,
  output logic      [2:0]  led_out,
  output logic             air_closes_valve_out,
  output logic             auto_tune_sel_out,
  output logic      [2:0]  preset_idx_out,
  output logic             store_open_stop_out,
  output logic             use_new_tune_out,
  output logic             irq_out,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out
);
  localparam logic [31:0] MIN_HOLD = 32'(`LCPB_MIN_HOLD_CYC);
  localparam logic [31:0] MAX_HOLD = 32'(`LCPB_MAX_HOLD_CYC);
  localparam logic [31:0] BLINK    = 32'(`LCPB_BLINK_CYC);

  lcpb_state_t s_r;
  lcpb_state_t s_nxt;
  lcpb_btn_t   btn;
  logic        any_btn;
  logic [3:0]  ev;
  logic        released;
  logic        in_window;
  logic        wr_go;
  logic [31:0] ctrl_w;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    btn = LCPB_BTN_NONE;
    if (stops_btn_in)
      btn = LCPB_BTN_STOPS;
    else if (upper_btn_in)
      btn = LCPB_BTN_UPPER;
    else if (tune_btn_in)
      btn = LCPB_BTN_TUNE;
    any_btn   = (btn != LCPB_BTN_NONE);
    released  = !any_btn && (s_r.held != 2'(LCPB_BTN_NONE));
    in_window = (s_r.hold_cnt >= MIN_HOLD) && (s_r.hold_cnt < MAX_HOLD);
    wr_go     = s_r.dphase && s_r.dwrite;
    ctrl_w    = (wr_go && s_r.daddr == `LCPB_CTRL_OFS) ? hwdata_in
                                                       : `LCPB_CTRL_RST;
    ev        = 4'h0;
    s_nxt     = s_r;
    s_nxt.store_open_stop = 1'b0;
    s_nxt.use_new_tune    = 1'b0;
    // Selector decode, frozen while a process runs
    if (s_r.mode == LCPB_NORMAL)
    begin
      s_nxt.air_closes_valve = selector_in[3];
      s_nxt.auto_tune_sel    = (selector_in[2:0] == 3'h0);
      s_nxt.preset_idx       = selector_in[2:0];
    end
    // Hold timer, saturates so over-long holds stay invalid
    if (any_btn)
    begin
      s_nxt.held = 2'(btn);
      if (s_r.hold_cnt != 32'hFFFF_FFFF)
        s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
    end
    else
    begin
      s_nxt.held     = 2'(LCPB_BTN_NONE);
      s_nxt.hold_cnt = 32'h0;
    end
    // Blink divider
    if (s_r.blink_cnt >= BLINK - 32'h1)
    begin
      s_nxt.blink_cnt = 32'h0;
      s_nxt.blink     = !s_r.blink;
    end
    else
      s_nxt.blink_cnt = s_r.blink_cnt + 32'h1;
    case (s_r.mode)
      LCPB_NORMAL:
      begin
        s_nxt.led = 3'h0;
        // Steady LED while hold is in window
        if (any_btn && in_window && btn == LCPB_BTN_STOPS)
          s_nxt.led = 3'b001;
        else if (any_btn && in_window)
          s_nxt.led = 3'b010;
        if (released && in_window)
        begin
          ev[`LCPB_EV_START] = 1'b1;
          s_nxt.blink        = 1'b1;
          s_nxt.blink_cnt    = 32'h0;
          case (s_r.held)
            2'(LCPB_BTN_STOPS): s_nxt.mode = LCPB_STOPS;
            2'(LCPB_BTN_UPPER): s_nxt.mode = LCPB_OPEN;
            default:            s_nxt.mode = LCPB_TUNE;
          endcase
        end
        else if (released)
          ev[`LCPB_EV_REJECT] = 1'b1;
      end
      LCPB_STOPS:
      begin
        s_nxt.led = {2'b00, s_r.blink};
        if (stops_done_in || ctrl_w[`LCPB_CTRL_STOPS_DONE])
        begin
          s_nxt.mode = LCPB_NORMAL;
          ev[`LCPB_EV_DONE] = 1'b1;
        end
      end
      LCPB_OPEN:
      begin
        s_nxt.led = {1'b0, s_r.blink, 1'b0};
        if (upper_btn_in && s_r.held == 2'(LCPB_BTN_UPPER)
            && s_r.hold_cnt == MIN_HOLD)
        begin
          s_nxt.store_open_stop = 1'b1;
          s_nxt.mode = LCPB_NORMAL;
          s_nxt.led  = 3'h0;
          ev[`LCPB_EV_DONE] = 1'b1;
        end
      end
      LCPB_TUNE:
      begin
        // Tuning itself runs in the positioning engine
        s_nxt.led = {s_r.blink, 2'b00};
        if (tune_done_in || ctrl_w[`LCPB_CTRL_TUNE_DONE])
        begin
          s_nxt.use_new_tune = 1'b1;
          s_nxt.mode = LCPB_NORMAL;
          ev[`LCPB_EV_DONE] = 1'b1;
        end
      end
      default:
        s_nxt.mode = LCPB_NORMAL;
    endcase
    // Cancel wins over everything; no store, no new tune
    if (cancel_btn_in && s_r.mode != LCPB_NORMAL)
    begin
      s_nxt.mode            = LCPB_NORMAL;
      s_nxt.led             = 3'h0;
      s_nxt.store_open_stop = 1'b0;
      s_nxt.use_new_tune    = 1'b0;
      ev                    = 4'h0;
      ev[`LCPB_EV_CANCEL]   = 1'b1;
    end
    // Interrupt registers: set beats clear
    s_nxt.irq_stat = s_r.irq_stat;
    if (wr_go && s_r.daddr == `LCPB_IRQ_CLR_OFS)
      s_nxt.irq_stat = s_r.irq_stat & ~hwdata_in[3:0];
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    if (wr_go && s_r.daddr == `LCPB_IRQ_EN_OFS)
      s_nxt.irq_en = hwdata_in[3:0];
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);
    // Bus: zero wait states, unmapped reads zero
    s_nxt.dphase = hsel_in && htrans_in[1] && hready_in;
    s_nxt.dwrite = hwrite_in;
    s_nxt.daddr  = haddr_in[11:0];
    s_nxt.rdata  = 32'h0;
    if (hsel_in && htrans_in[1] && hready_in && !hwrite_in)
    begin
      case (haddr_in[11:0])
        `LCPB_STAT_OFS:
          s_nxt.rdata = {17'h0, s_r.preset_idx, s_r.auto_tune_sel,
                         s_r.air_closes_valve, 3'h0, s_r.led,
                         s_r.mode};
        `LCPB_IRQ_STAT_OFS: s_nxt.rdata = {28'h0, s_r.irq_stat};
        `LCPB_IRQ_EN_OFS:   s_nxt.rdata = {28'h0, s_r.irq_en};
        default:            s_nxt.rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      s_r           <= '0;
      s_r.mode      <= LCPB_NORMAL;
      s_r.irq_en    <= `LCPB_IRQ_EN_RST;
    end
    else if (clk_en_in)
      s_r <= s_nxt;
  end

  assign mode_out             = s_r.mode;
  assign led_out              = s_r.led;
  assign air_closes_valve_out = s_r.air_closes_valve;
  assign auto_tune_sel_out    = s_r.auto_tune_sel;
  assign preset_idx_out       = s_r.preset_idx;
  assign store_open_stop_out  = s_r.store_open_stop;
  assign use_new_tune_out     = s_r.use_new_tune;
  assign irq_out              = s_r.irq;
  assign hrdata_out           = s_r.rdata;
  assign hreadyout_out        = 1'b1;
  assign hresp_out            = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  property p_one_hot;
    @(posedge clk_in) disable iff (reset_in) $onehot(s_r.mode);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("mode not one-hot");

  property p_air;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_NORMAL) |=>
      air_closes_valve_out == $past(selector_in[3]);
  endproperty
  a_air: assert property (p_air) else $error("air action wrong");

  property p_auto;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_NORMAL && selector_in[2:0] == 3'h0)
      |=> auto_tune_sel_out;
  endproperty
  a_auto: assert property (p_auto) else $error("auto tune not selected");

  property p_preset;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_NORMAL) |=>
      preset_idx_out == $past(selector_in[2:0]);
  endproperty
  a_preset: assert property (p_preset) else $error("preset wrong");

  property p_stops_blink;
    @(posedge clk_in) disable iff (reset_in)
      (s_r.mode == LCPB_STOPS && $past(s_r.mode) == LCPB_STOPS)
      |-> led_out[2:1] == 2'b00;
  endproperty
  a_stops_blink: assert property (p_stops_blink) else $error("LED1 only");

  property p_stops_done;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_STOPS && stops_done_in)
      |=> mode_out == LCPB_NORMAL;
  endproperty
  a_stops_done: assert property (p_stops_done) else $error("no return");

  property p_tune_done;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_TUNE && tune_done_in && !cancel_btn_in)
      |=> use_new_tune_out && mode_out == LCPB_NORMAL ##1 !use_new_tune_out
          || !clk_en_in;
  endproperty
  a_tune_done: assert property (p_tune_done) else $error("tune end");

  property p_cancel;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && cancel_btn_in && s_r.mode != LCPB_NORMAL) |=>
      mode_out == LCPB_NORMAL && led_out == 3'h0 && !store_open_stop_out
      && !use_new_tune_out;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel failed");

  property p_short;
    @(posedge clk_in) disable iff (reset_in)
      (clk_en_in && s_r.mode == LCPB_NORMAL && released
       && s_r.hold_cnt < MIN_HOLD) |=> mode_out == LCPB_NORMAL;
  endproperty
  a_short: assert property (p_short) else $error("short hold started");

  property p_store;
    @(posedge clk_in) disable iff (reset_in)
      store_open_stop_out |-> mode_out == LCPB_NORMAL && led_out == 3'h0
      && $past(s_r.mode) == LCPB_OPEN;
  endproperty
  a_store: assert property (p_store) else $error("store wrong");
endmodule : lcpb_ctrl
`default_nettype wire

/* verif/lcpb_operator.sv */
// Operator model at the front panel buttons and selector
`timescale 1ns/1ps
`default_nettype none
module lcpb_operator
(
  // Clock
  input  wire logic       clk_in,
  // Panel
  output logic      [3:0] btn_out,
  output logic      [3:0] selector_out
);
  initial
  begin
    btn_out = 4'h0;
    selector_out = 4'h0;
  end
  // Bit order: stops, upper, tune, cancel
  task automatic press(input logic [3:0] mask, input int cyc);
    btn_out <= mask;
    repeat (cyc) @(posedge clk_in);
    btn_out <= 4'h0;
    @(posedge clk_in);
  endtask : press
  task automatic set_sel(input logic [3:0] s);
    selector_out <= s;
    @(posedge clk_in);
  endtask : set_sel
endmodule : lcpb_operator
`default_nettype wire

/* verif/local_commissioning_pushbutton_ctrl_bench.sv */
// Self-checking bench of the pushbutton commissioning controller
`timescale 1ns/1ps
`include "lcpb_map.svh"
`default_nettype none
module local_commissioning_pushbutton_ctrl_bench;
  import lcpb_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        en = 1'b1;
  logic        sdone = 1'b0;
  logic        tdone = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [3:0]  s;
  wire  [3:0]  btn, sel, mode;
  wire  [2:0]  led, preset;
  wire  [31:0] hrdata;
  wire         air_c, auto_s, store_p, tune_p, irq, hready, hresp;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n_pulse = 0;
  always #5 clk_in = ~clk_in;
  lcpb_operator u_op (.clk_in(clk_in), .btn_out(btn), .selector_out(sel));
  lcpb_ctrl u_dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en),
    .stops_btn_in(btn[0]), .upper_btn_in(btn[1]), .tune_btn_in(btn[2]),
    .cancel_btn_in(btn[3]), .selector_in(sel), .stops_done_in(sdone),
    .tune_done_in(tdone), .mode_out(mode), .led_out(led),
    .air_closes_valve_out(air_c), .auto_tune_sel_out(auto_s),
    .preset_idx_out(preset), .store_open_stop_out(store_p),
    .use_new_tune_out(tune_p), .irq_out(irq), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_stat(input logic [3:0] v);
    // Status word: preset, auto, air, pad, LEDs off, mode
    return {17'h0, v[2:0], v[2:0] == 3'h0, v[3], 6'h0, LCPB_NORMAL};
  endfunction : exp_stat
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    r = hrdata;
  endtask : bus
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  // Hang guard well above the few hundred cycles the tests take
  always @(posedge clk_in)
  begin
    cyc++;
    if (store_p === 1'b1 || tune_p === 1'b1)
      n_pulse++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    rd = $urandom(32'hE6CF8E30);
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    chk("mode", 32'(LCPB_NORMAL), 32'(mode));
    chk("led", 32'h0, 32'(led));
    chk("irq", 32'h0, 32'(irq));
    bus(1'b0, `LCPB_IRQ_EN_OFS, 32'h0, rd);
    chk("irq_en", 32'(`LCPB_IRQ_EN_RST), rd);
    $display("test reset done");
    for (int i = 0; i < 36; i++)
    begin
      s = (i < 16) ? 4'(i) : 4'($urandom_range(15));
      u_op.set_sel(s);
      repeat (2) @(posedge clk_in);
      chk("air", 32'(s[3]), 32'(air_c));
      chk("auto", 32'(s[2:0] == 3'h0), 32'(auto_s));
      chk("preset", 32'(s[2:0]), 32'(preset));
      bus(1'b0, `LCPB_STAT_OFS, 32'h0, rd);
      chk("stat", exp_stat(s), rd);
    end
    // Enable low must freeze the selector decode
    en <= 1'b0;
    u_op.set_sel(~s);
    repeat (2) @(posedge clk_in);
    chk("air_frozen", 32'(s[3]), 32'(air_c));
    en <= 1'b1;
    s = ~s;
    repeat (2) @(posedge clk_in);
    chk("air_resumed", 32'(s[3]), 32'(air_c));
    $display("test selector done");
    // Real hold windows are seconds long, so only short holds fit
    for (int b = 0; b < 3; b++)
    begin
      u_op.press(4'(1 << b), 1 + $urandom_range(40));
      repeat (3) @(posedge clk_in);
      chk("mode", 32'(LCPB_NORMAL), 32'(mode));
      chk("led", 32'h0, 32'(led));
      bus(1'b0, `LCPB_IRQ_STAT_OFS, 32'h0, rd);
      chk("reject", 32'h8, rd & 32'h8);
      chk("irq_masked", 32'h0, 32'(irq));
      bus(1'b1, `LCPB_IRQ_EN_OFS, 32'h8, rd);
      repeat (3) @(posedge clk_in);
      chk("irq_on", 32'h1, 32'(irq));
      bus(1'b1, `LCPB_IRQ_CLR_OFS, 32'hF, rd);
      repeat (3) @(posedge clk_in);
      chk("irq_clr", 32'h0, 32'(irq));
      bus(1'b1, `LCPB_IRQ_EN_OFS, 32'h0, rd);
    end
    $display("test short holds done");
    u_op.press(4'h8, 5);
    sdone <= 1'b1;
    tdone <= 1'b1;
    @(posedge clk_in);
    sdone <= 1'b0;
    tdone <= 1'b0;
    bus(1'b1, `LCPB_CTRL_OFS, 32'h3, rd);
    repeat (3) @(posedge clk_in);
    chk("mode", 32'(LCPB_NORMAL), 32'(mode));
    chk("pulses", 32'h0, 32'(n_pulse));
    $display("test idle events done");
    bus(1'b0, 12'h020, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, 32'(hresp));
    chk("hready", 32'h1, 32'(hready));
    bus(1'b1, `LCPB_STAT_OFS, 32'hFFFF_FFFF, rd);
    bus(1'b0, `LCPB_STAT_OFS, 32'h0, rd);
    chk("stat_ro", exp_stat(s), rd);
    $display("test bus map done");
    give_verdict();
  end
endmodule : local_commissioning_pushbutton_ctrl_bench
`default_nettype wire
